// file: include/hwm_pkg.sv
// hwm_pkg: constants, types and helpers of the hardware monitor sequencer
// Contract
// - ARA acknowledged only with enable and event
// - ARA answer byte carries own address
// - ARA acknowledge clears global interrupt enable
// - re-enabled alert reasserts on next conversion
// - ARA answered regardless of pin routing
// - alert pulled low for enabled limit status bit
// - limit equal or beyond sets status bit
// - power-up defaults everywhere except readings
// - configuration bit 7 soft resets, self-clears
// - special function bit 1 picks cycle mode
// - temperature 96, voltage 68 conversion clocks
// - averaging top bit forces 32 samples
// - averaging counts follow field per input
// - averaging field resets to 010
// - fixed order diode1, ambient, vcc, vccp, diode2
// - continuous mode restarts pass at once
// - cycle mode idles about one second
// - readings updated once per pass
// - start low stops, sleep or shutdown
// - status read clears only inactive causes
package hwm_pkg;
    // register offsets
    localparam logic [7:0] A_START   = 8'h40;
    localparam logic [7:0] A_STAT1   = 8'h41;
    localparam logic [7:0] A_STAT2   = 8'h42;
    localparam logic [7:0] A_LIM0    = 8'h44;
    localparam logic [7:0] A_READ0   = 8'h20;
    localparam logic [7:0] A_SFR     = 8'h7C;
    localparam logic [7:0] A_VOLT_EN = 8'h7E;
    localparam logic [7:0] A_CONFIG  = 8'h7F;
    localparam logic [7:0] A_FAN_EN  = 8'h80;
    localparam logic [7:0] A_TEMP_EN = 8'h82;
    // field positions
    localparam int B_START = 0;
    localparam int B_LOCK  = 1;
    localparam int B_LOW_PWR = 0;
    localparam int B_CYC     = 1;
    localparam int B_IRQ_EN  = 2;
    localparam int B_AVG   = 5;
    localparam int B_SRST  = 7;
    localparam int B_ROUTE_SPD = 0;
    localparam int B_ROUTE_DRV = 1;
    localparam int B_GRP   = 0;
    localparam int B_IND   = 1;
    // values after reset
    localparam logic [2:0] AVG_RST    = 3'h2;
    localparam logic [7:0] LIM_LO_RST = 8'h00;
    localparam logic [7:0] LIM_HI_RST = 8'hFF;
    // bus addresses
    localparam logic [6:0] ARA_ADDR      = 7'h0C;
    localparam logic [6:0] SLAVE_ADDR_DF = 7'h2E;
    // conversion timing in conversion clock periods
    localparam int unsigned CONV_KHZ   = 45;
    localparam logic [6:0]  TEMP_TICKS = 7'h60;
    localparam logic [6:0]  VOLT_TICKS = 7'h44;
    localparam int unsigned GAP_MS     = 1000;
    localparam int unsigned GAP_TICKS  = CONV_KHZ * GAP_MS;
    // channels in sampling order
    localparam int unsigned NCH = 5;
    localparam logic [2:0] CH_RD1  = 3'h0;
    localparam logic [2:0] CH_AMB  = 3'h1;
    localparam logic [2:0] CH_VCC  = 3'h2;
    localparam logic [2:0] CH_VCCP = 3'h3;
    localparam logic [2:0] CH_RD2  = 3'h4;

    typedef enum logic [1:0] {ST_OFF, ST_CONV, ST_GAP} hwm_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } hwm_bus_s;

    function automatic logic is_temp(input logic [2:0] ch);
        return (ch != CH_VCC) && (ch != CH_VCCP);
    endfunction : is_temp

    // log2 of samples per reading; top bit wins
    function automatic logic [2:0] avg_shift(input logic [2:0] sel, input logic [2:0] ch);
        logic remote;
        remote = (ch == CH_RD1) || (ch == CH_RD2);
        casez (sel)
            3'b1??:  return 3'h5;
            3'b01?:  return 3'h4;
            3'b001:  return remote ? 3'h4 : 3'h0;
            default: return remote ? 3'h7 : 3'h3;
        endcase
    endfunction : avg_shift
endpackage : hwm_pkg

// file: core/hwm_sync.sv
// hwm_sync: two-flop synchroniser with rising-edge detect
`timescale 1ns/10ps
`default_nettype none
module hwm_sync #(
    parameter int unsigned W = 1
) (
    // clock and control
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // asynchronous levels
    input  wire logic [W-1:0] d,
    // synchronised levels and edges
    output logic      [W-1:0] q,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta;
    logic [W-1:0] last;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= '0;
            q    <= '0;
            last <= '0;
        end
        else if (ce)
        begin
            meta <= d;
            q    <= meta;
            last <= q;
        end
    end

    // edge taken only between second and third flop
    assign rise = ce ? (q & ~last) : '0;
endmodule : hwm_sync
`default_nettype wire

// file: core/hwm_avg.sv
// hwm_avg: sample accumulator dividing by a power of two
`timescale 1ns/10ps
`default_nettype none
module hwm_avg #(
    parameter int unsigned DW = 8,
    parameter int unsigned SW = 3
) (
    // clock and control
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          clr,
    // samples
    input  wire logic          smp_valid,
    input  wire logic [DW-1:0] smp,
    input  wire logic [SW-1:0] shift,
    // averaged result
    output logic               done,
    output logic      [DW-1:0] result
);
    localparam int unsigned CW = 2 ** SW;
    localparam int unsigned AW = DW + CW - 1;

    logic [AW-1:0] acc;
    logic [AW-1:0] sum;
    logic [CW-1:0] cnt;
    logic          last;

    assign sum  = acc + AW'(smp);
    assign last = cnt == CW'((32'h1 << shift) - 32'h1);

    always_ff @(posedge clk)
    begin
        if (rst || (ce && clr))
        begin
            acc <= '0;
            cnt <= '0;
        end
        else if (ce && smp_valid)
        begin
            acc <= last ? '0 : sum;
            cnt <= last ? '0 : cnt + CW'(1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done   <= 1'b0;
            result <= '0;
        end
        else if (ce)
        begin
            done <= smp_valid && last && !clr;
            if (smp_valid && last)
                result <= DW'(sum >> shift);
        end
    end

    count_done_a: assert property (@(posedge clk) disable iff (rst)
        (ce && smp_valid && !clr && cnt == CW'((32'h1 << shift) - 32'h1)) |=> done)
        else $error("average not completed at programmed sample count");
endmodule : hwm_avg
`default_nettype wire

// file: core/hwm_monitor.sv
// hwm_monitor: conversion sequencer, limit status and alert response
`timescale 1ns/10ps
`default_nettype none
module hwm_monitor
    import hwm_pkg::*;
#(
    parameter int unsigned GAP_TICKS  = hwm_pkg::GAP_TICKS,
    parameter logic [6:0]  SLAVE_ADDR = hwm_pkg::SLAVE_ADDR_DF
) (
    // clock, reset, freeze
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // register port
    input  wire hwm_pkg::hwm_bus_s bus,
    output logic      [7:0]       rdata,
    // conversion clock and diode fault pins
    input  wire logic             conv_clk,
    input  wire logic [1:0]       diode_fault,
    // converter
    output logic      [2:0]       adc_sel,
    output logic                  adc_take,
    input  wire logic [7:0]       adc_data,
    // alert response
    input  wire logic             ara_query,
    output logic                  ara_ack,
    output logic      [7:0]       ara_byte,
    // open-drain interrupt pins
    output logic                  alert_out,
    output logic                  drive_two_int_oe_n,
    output logic                  speed_three_int_oe_n,
    // power state
    output logic                  monitoring,
    output logic                  sleep,
    output logic                  shutdown
);
    localparam int unsigned GW = $clog2(GAP_TICKS + 1);

    hwm_state_e  st;
    logic [2:0]  ch;
    logic [6:0]  tick_cnt;
    logic [GW-1:0] gap_cnt;
    logic        start, lock, low_power_select, cyc_mode, global_irq_enable;
    logic [2:0]  avg_sel;
    logic [1:0]  int_route;
    logic        volt_grp, fan_grp, temp_grp;
    logic [1:0]  volt_ind;
    logic [2:0]  temp_ind;
    logic [4:0]  stat1, viol, en_vec, grp_mask, set1;
    logic [1:0]  stat2, fault_s, f_set;
    logic [7:0]  reading [NCH];
    logic [7:0]  lim_lo [NCH];
    logic [7:0]  lim_hi [NCH];
    logic [7:0]  rmux, avg_res;
    logic [2:0]  pin_q, pin_rise;
    logic        tick, avg_done, commit, commit_q, viol_new, event_on;
    logic        srst_hit, rd_s1, rd_s2, alert_drv, ara_ok;
    logic [6:0]  conv_last;

    function automatic logic wr_at(input logic [7:0] a);
        return bus.wr && (bus.addr == a);
    endfunction : wr_at

    hwm_sync #(.W(3)) u_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .d    ({diode_fault, conv_clk}),
        .q    (pin_q),
        .rise (pin_rise)
    );

    assign tick    = pin_rise[0];
    assign fault_s = pin_q[2:1];

    // soft reset acts like power-up except on readings
    assign srst_hit = ce && wr_at(A_CONFIG) && bus.wdata[B_SRST];
    assign rd_s1    = ce && bus.rd && (bus.addr == A_STAT1);
    assign rd_s2    = ce && bus.rd && (bus.addr == A_STAT2);

    assign conv_last = (is_temp(ch) ? TEMP_TICKS : VOLT_TICKS) - 7'h01;
    assign adc_take  = ce && (st == ST_CONV) && start && tick && (tick_cnt == conv_last);
    assign adc_sel   = ch;

    hwm_avg #(.DW(8), .SW(3)) u_avg (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .clr       (st == ST_OFF),
        .smp_valid (adc_take),
        .smp       (adc_data),
        .shift     (avg_shift(avg_sel, ch)),
        .done      (avg_done),
        .result    (avg_res)
    );

    assign commit = ce && avg_done && (st == ST_CONV);

    // configuration, enables and the start/lock register
    always_ff @(posedge clk)
    begin
        if (rst || srst_hit)
        begin
            start     <= 1'b0;
            lock      <= 1'b0;
            low_power_select  <= 1'b0;
            cyc_mode  <= 1'b0;
            global_irq_enable <= 1'b0;
            avg_sel   <= AVG_RST;
            int_route <= 2'h0;
            volt_grp  <= 1'b0;
            fan_grp   <= 1'b0;
            temp_grp  <= 1'b0;
            volt_ind  <= 2'h0;
            temp_ind  <= 3'h0;
        end
        else if (ce)
        begin
            // a software write of the enable in the same cycle overrides this
            if (ara_ok)
                global_irq_enable <= 1'b0;
            if (wr_at(A_START))
            begin
                if (!lock)
                    start <= bus.wdata[B_START];
                lock <= lock | bus.wdata[B_LOCK];
            end
            if (wr_at(A_SFR))
            begin
                avg_sel  <= bus.wdata[B_AVG +: 3];
                cyc_mode <= bus.wdata[B_CYC];
                global_irq_enable <= bus.wdata[B_IRQ_EN];
                if (!lock)
                    low_power_select <= bus.wdata[B_LOW_PWR];
            end
            if (wr_at(A_CONFIG))
                int_route <= {bus.wdata[B_ROUTE_DRV], bus.wdata[B_ROUTE_SPD]};
            if (wr_at(A_VOLT_EN))
            begin
                volt_grp <= bus.wdata[B_GRP];
                volt_ind <= bus.wdata[B_IND +: 2];
            end
            if (wr_at(A_FAN_EN))
                fan_grp <= bus.wdata[B_GRP];
            if (wr_at(A_TEMP_EN))
            begin
                temp_grp <= bus.wdata[B_GRP];
                temp_ind <= bus.wdata[B_IND +: 3];
            end
        end
    end

    // limits: low then high per channel
    always_ff @(posedge clk)
    begin
        if (rst || srst_hit)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                lim_lo[i] <= LIM_LO_RST;
                lim_hi[i] <= LIM_HI_RST;
            end
        end
        else if (ce && bus.wr)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (bus.addr == A_LIM0 + 8'(2 * i))
                    lim_lo[i] <= bus.wdata;
                if (bus.addr == A_LIM0 + 8'(2 * i + 1))
                    lim_hi[i] <= bus.wdata;
            end
        end
    end

    // readings keep no reset so a soft reset leaves the last pass visible
    always_ff @(posedge clk)
    begin
        if (commit)
            reading[ch] <= avg_res;
    end

    // sequencer
    always_ff @(posedge clk)
    begin
        if (rst || srst_hit)
        begin
            st       <= ST_OFF;
            ch       <= CH_RD1;
            tick_cnt <= 7'h00;
            gap_cnt  <= '0;
        end
        else if (ce)
        begin
            case (st)
                ST_OFF:
                begin
                    ch       <= CH_RD1;
                    tick_cnt <= 7'h00;
                    if (start)
                        st <= ST_CONV;
                end
                ST_CONV:
                begin
                    if (!start)
                        st <= ST_OFF;
                    else
                    begin
                        if (tick)
                            tick_cnt <= adc_take ? 7'h00 : tick_cnt + 7'h01;
                        if (avg_done)
                        begin
                            gap_cnt <= '0;
                            if (ch == CH_RD2)
                            begin
                                ch <= CH_RD1;
                                if (cyc_mode)
                                    st <= ST_GAP;
                            end
                            else
                                ch <= ch + 3'h1;
                        end
                    end
                end
                ST_GAP:
                begin
                    if (!start)
                        st <= ST_OFF;
                    else if (tick)
                    begin
                        if (gap_cnt == GW'(GAP_TICKS - 1))
                            st <= ST_CONV;
                        else
                            gap_cnt <= gap_cnt + GW'(1);
                    end
                end
                default: st <= ST_OFF;
            endcase
        end
    end

    // limit check on the averaged value as it is committed; equal counts
    assign viol_new = (avg_res <= lim_lo[ch]) || (avg_res >= lim_hi[ch]);
    assign en_vec   = {temp_ind[2], volt_ind[1], volt_ind[0], temp_ind[1], temp_ind[0]};
    assign grp_mask = {temp_grp, volt_grp, volt_grp, temp_grp, temp_grp};
    assign set1     = commit ? ((5'h01 << ch) & en_vec & {5{viol_new}}) : 5'h00;
    assign f_set    = fault_s & {temp_ind[2], temp_ind[0]};

    always_ff @(posedge clk)
    begin
        if (rst || srst_hit)
        begin
            viol     <= 5'h00;
            stat1    <= 5'h00;
            stat2    <= 2'h0;
            commit_q <= 1'b0;
        end
        else if (ce)
        begin
            commit_q <= commit;
            if (commit)
                viol[ch] <= viol_new;
            // new events win over a read that clears
            stat1 <= (rd_s1 ? (stat1 & viol) : stat1) | set1;
            stat2 <= (rd_s2 ? (stat2 & fault_s) : stat2) | f_set;
        end
    end

    // diode fault bits stay off the alert; only grouped limit bits count
    assign event_on = |(stat1 & grp_mask);
    assign ara_ok   = ce && ara_query && global_irq_enable && event_on;
    assign ara_ack  = ara_ok;

    always_ff @(posedge clk)
        ara_byte <= {SLAVE_ADDR, 1'b0};

    // drops at once, re-arms only on a later conversion commit
    always_ff @(posedge clk)
    begin
        if (rst || srst_hit)
            alert_drv <= 1'b0;
        else if (ce)
        begin
            if (global_irq_enable && event_on && monitoring)
                alert_drv <= alert_drv | commit_q;
            else
                alert_drv <= 1'b0;
        end
    end

    assign alert_out            = 1'b0;
    assign drive_two_int_oe_n   = ~(alert_drv & int_route[1]);
    assign speed_three_int_oe_n = ~(alert_drv & int_route[0]);
    assign monitoring           = (st != ST_OFF);
    assign sleep                = !start && !low_power_select;
    assign shutdown             = !start && low_power_select;

    always_comb
    begin
        rmux = 8'h00;
        for (int i = 0; i < NCH; i++)
        begin
            if (bus.addr == A_READ0 + 8'(i))
                rmux = reading[i];
            if (bus.addr == A_LIM0 + 8'(2 * i))
                rmux = lim_lo[i];
            if (bus.addr == A_LIM0 + 8'(2 * i + 1))
                rmux = lim_hi[i];
        end
        case (bus.addr)
            A_START:   rmux = {6'h00, lock, start};
            A_STAT1:   rmux = {3'h0, stat1};
            A_STAT2:   rmux = {6'h00, stat2};
            A_SFR:     rmux = {avg_sel, 2'h0, global_irq_enable, cyc_mode, low_power_select};
            A_VOLT_EN: rmux = {5'h00, volt_ind, volt_grp};
            A_CONFIG:  rmux = {6'h00, int_route};
            A_FAN_EN:  rmux = {7'h00, fan_grp};
            A_TEMP_EN: rmux = {4'h0, temp_ind, temp_grp};
            default:   rmux = rmux;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (ce)
            rdata <= bus.rd ? rmux : 8'h00;
    end

    // checks
    logic [4:0] keep_q;
    always_ff @(posedge clk)
        keep_q <= stat1 & viol;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (rst);

    sequence pass_end;
        commit && ch == CH_RD2;
    endsequence

    ara_gate_a: assert property (ara_ack |-> global_irq_enable && event_on)
        else $error("alert response acknowledged without enabled event");
    ara_byte_a: assert property (ara_ack |-> ara_byte[7:1] == SLAVE_ADDR)
        else $error("alert response byte lacks own address");
    ara_clear_a: assert property (ara_ack && !wr_at(A_SFR) |=>
        !global_irq_enable ##1 !alert_drv)
        else $error("global enable not cleared after alert response");
    alert_arm_a: assert property ($rose(alert_drv) |->
        $past(commit_q) && global_irq_enable)
        else $error("alert asserted outside a conversion commit");
    conv_len_a: assert property (adc_take |-> tick_cnt == (is_temp(ch) ? 7'h5F : 7'h43))
        else $error("conversion length wrong");
    avg_prio_a: assert property (avg_sel[2] |-> avg_shift(avg_sel, ch) == 3'h5)
        else $error("top averaging bit not forcing 32 samples");
    seq_wrap_a: assert property (pass_end ##0 !cyc_mode ##0 start |=> st == ST_CONV && ch == CH_RD1)
        else $error("continuous pass not restarted");
    seq_gap_a: assert property (pass_end ##0 cyc_mode ##0 start |=> st == ST_GAP && gap_cnt == '0)
        else $error("cycle mode did not idle after pass");
    seq_step_a: assert property (commit && ch != CH_RD2 && start |=> ch == $past(ch) + 3'h1)
        else $error("channel order broken");
    soft_rst_a: assert property (srst_hit |=>
        avg_sel == AVG_RST && !global_irq_enable && !start)
        else $error("soft reset did not restore defaults");
    stat_keep_a: assert property (rd_s1 |=> (stat1 & keep_q) == keep_q)
        else $error("active status bit cleared by read");
endmodule : hwm_monitor
`default_nettype wire

// file: bench/hwm_partner.sv
// hwm_partner: conversion clock, converter data and alert-querying host
`timescale 1ns/10ps
`default_nettype none
module hwm_partner (
    // system clock
    input  wire logic       clk,
    // converter side
    input  wire logic       adc_take,
    output logic            conv_clk,
    output logic      [7:0] adc_data,
    // alert response side
    output logic            ara_query,
    input  wire logic       ara_ack
);
    // the conversion oscillator runs free, so the clock never stops
    initial
    begin
        conv_clk = 1'b0;
        forever #24 conv_clk = ~conv_clk;
    end

    initial ara_query = 1'b0;

    // data outside the sample cycle is inverted so a late sample shows up
    assign adc_data = adc_take ? 8'h40 : 8'hBF;

    // query held for one cycle, acknowledge sampled at the edge that ends it
    task automatic alert_query(output logic ack);
        @(posedge clk);
        ara_query <= 1'b1;
        @(posedge clk);
        ack = ara_ack;
        ara_query <= 1'b0;
    endtask : alert_query
endmodule : hwm_partner
`default_nettype wire

// file: bench/hwm_monitor_tb.sv
// hwm_monitor_tb: register-level tests of the monitor sequencer
`timescale 1ns/10ps
`default_nettype none
module hwm_monitor_tb;
    import hwm_pkg::*;
    logic             clk;
    logic             rst;
    hwm_pkg::hwm_bus_s bus;
    logic      [7:0]  rdata;
    logic             conv_clk;
    logic      [2:0]  adc_sel;
    logic             adc_take;
    logic      [7:0]  adc_data;
    logic             ara_query;
    logic             ara_ack;
    logic      [7:0]  ara_byte;
    logic             alert_out;
    logic             p2_oe_n;
    logic             t3_oe_n;
    logic             monitoring;
    logic             sleep;
    logic             shutdown;
    logic             ack;
    int               fail_count;
    int               compares;
    int               cycles;
    logic      [1:0]  fault;
    int               span;

    hwm_monitor #(.GAP_TICKS(20)) hwm_monitor_i (
        .clk(clk), .rst(rst), .ce(1'b1), .bus(bus), .rdata(rdata),
        .conv_clk(conv_clk), .diode_fault(fault), .adc_sel(adc_sel),
        .adc_take(adc_take), .adc_data(adc_data), .ara_query(ara_query),
        .ara_ack(ara_ack), .ara_byte(ara_byte), .alert_out(alert_out),
        .drive_two_int_oe_n(p2_oe_n), .speed_three_int_oe_n(t3_oe_n),
        .monitoring(monitoring), .sleep(sleep), .shutdown(shutdown)
    );

    hwm_partner hwm_partner_i (
        .clk(clk), .adc_take(adc_take), .conv_clk(conv_clk),
        .adc_data(adc_data), .ara_query(ara_query), .ara_ack(ara_ack)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd

    // bounded wait for the sequencer to reach a channel
    task automatic wait_sel(input logic [2:0] ch, input int limit);
        int n;
        n = 0;
        while (adc_sel !== ch && n < limit)
        begin
            @(posedge clk);
            n++;
        end
        #1;
    endtask : wait_sel

    task automatic stop_test;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // the whole sequence needs about 33000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 45000)
        begin
            fail_count++;
            stop_test();
        end
    end

    initial
    begin
        fail_count = 0;
        compares = 0;
        cycles = 0;
        bus = '0;
        fault = 2'b00;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(A_SFR, 8'h40);
        rd(A_LIM0, LIM_LO_RST);
        rd(A_LIM0 + 8'h01, LIM_HI_RST);
        rd(A_STAT1, 8'h00);
        rd(8'h10, 8'h00);
        check({7'h00, sleep}, 8'h01);
        // averaging 001: diodes 16 samples, ambient and supplies one each
        wr(A_SFR, 8'h24);
        wr(A_TEMP_EN, 8'h0F);
        wr(A_VOLT_EN, 8'h07);
        wr(A_CONFIG, 8'h02);
        wr(A_LIM0 + 8'h03, 8'h10);
        hwm_partner_i.alert_query(ack);
        check({7'h00, ack}, 8'h00);
        check({7'h00, p2_oe_n}, 8'h01);
        wr(A_START, 8'h01);
        @(posedge clk);
        #1 check({7'h00, monitoring}, 8'h01);
        check({5'h00, adc_sel}, 8'h00);
        wait_sel(CH_AMB, 20000);
        check({5'h00, adc_sel}, 8'h01);
        wait_sel(CH_VCC, 2000);
        check({5'h00, adc_sel}, 8'h02);
        repeat (3) @(posedge clk);
        rd(A_READ0 + 8'h01, 8'h40);
        rd(A_STAT1, 8'h02);
        rd(A_STAT1, 8'h02);
        #1 check({7'h00, p2_oe_n}, 8'h00);
        check({7'h00, t3_oe_n}, 8'h01);
        check({7'h00, alert_out}, 8'h00);
        hwm_partner_i.alert_query(ack);
        check({7'h00, ack}, 8'h01);
        check(ara_byte, {SLAVE_ADDR_DF, 1'b0});
        repeat (2) @(posedge clk);
        #1 check({7'h00, p2_oe_n}, 8'h01);
        rd(A_SFR, 8'h20);
        wr(A_SFR, 8'h24);
        wait_sel(CH_VCCP, 2000);
        repeat (4) @(posedge clk);
        #1 check({7'h00, p2_oe_n}, 8'h00);
        // diode fault level: set through the sync, then cleared by a read once gone
        @(posedge clk);
        fault <= 2'b01;
        repeat (4) @(posedge clk);
        rd(A_STAT2, 8'h01);
        @(posedge clk);
        fault <= 2'b00;
        repeat (4) @(posedge clk);
        rd(A_STAT2, 8'h01);
        rd(A_STAT2, 8'h00);
        // cycle mode: the idle gap delays the first sample of the next pass
        wr(A_SFR, 8'h26);
        wait_sel(CH_RD1, 20000);
        span = 0;
        while (!adc_take && span < 2000)
        begin
            @(posedge clk);
            #1 span++;
        end
        check({7'h00, span > 1000}, 8'h01);
        rd(A_READ0 + 8'h04, 8'h40);
        wr(A_START, 8'h00);
        @(posedge clk);
        #1 check({6'h00, monitoring, sleep}, 8'h01);
        wr(A_SFR, 8'h21);
        #1 check({7'h00, shutdown}, 8'h01);
        wr(A_CONFIG, 8'h80);
        rd(A_CONFIG, 8'h00);
        rd(A_SFR, 8'h40);
        rd(A_LIM0 + 8'h03, LIM_HI_RST);
        rd(A_READ0 + 8'h01, 8'h40);
        stop_test();
    end
endmodule : hwm_monitor_tb
`default_nettype wire
